/* bench/tb_top.sv */
// testbench of the program flash write control block: register reset
// values, unmapped access, table writes, unlock, programming, aborts, irq.
// assumes pfwc_top with a zero-wait APB slave and a 250 MHz clock.
`timescale 1ns/100ps
module tb_top;
  import pfwc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // signals
  logic                   clk_sys;      // system clock
  logic                   reset_n;      // async reset, active low
  logic                   psel;         // apb select
  logic                   penable;      // apb access phase
  logic                   pwrite;       // apb direction
  logic [APB_AW-1:0]      paddr;        // apb byte address
  logic [31:0]            pwdata;       // apb write data
  logic [31:0]            prdata;       // apb read data
  logic                   pready;       // apb ready
  logic                   pslverr;      // apb error
  logic                   mclrRst;      // master clear reset event
  logic                   wdogRst;      // watchdog reset event
  logic                   cpuStall;     // cpu held while writing
  logic                   irq;          // level interrupt
  pfwc_flash_wr_t         flashWr;      // byte stream to the array
  int                     nMismatch;    // failed comparisons
  int                     checked;      // comparisons made
  int                     nValid;       // byte strobes seen
  int                     stallCnt;     // cycles with cpu stalled
  logic [PTR_W-1:0]       expBase;      // pointer at start of block
  logic                   expCfg;       // expected config space flag
  logic [7:0]             expHold [64]; // bytes loaded by table writes
  logic [31:0]            rd;           // last read data
  logic                   err;          // last slave error

  pfwc_top i_dut
  (
    .clk_sys            (clk_sys),
    .reset_n            (reset_n),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .masterClearReset   (mclrRst),
    .watchdogTimerReset (wdogRst),
    .cpuStall           (cpuStall),
    .irq                (irq),
    .flashWr            (flashWr)
  );

  // free running clock, 4 ns period
  always #2 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  // comparison and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // block base taken from the pointer, byte index in the low bits
  function automatic logic [PTR_W-1:0] exp_addr(input logic [PTR_W-1:0] b,
                                                input int i);
    return {b[PTR_W-1:6], i[5:0]};
  endfunction : exp_addr

  ////////////////////////////////////////////////////////////////////////////
  // apb master: setup, access held until pready, then release
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    if (n >= 50)
    begin
      nMismatch++;
      tally_and_finish();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask : rdr

  // settings, first key, optional stray write, second key, then start bit
  task automatic start(input logic [7:0] ctl, input logic brk);
    wr(OFF_CTRL, {24'h0, ctl});
    wr(OFF_UNLOCK, 32'h55);
    if (brk)
      wr(OFF_LATCH, 32'h0);
    wr(OFF_UNLOCK, 32'hAA);
    wr(OFF_CTRL, {24'h0, ctl | 8'h02});
  endtask : start

  // load one block through latch and table write, then rewind pointer
  task automatic fill(input logic cfg);
    expBase = {cfg, 5'($urandom), 8'($urandom), 8'h40};
    expCfg  = cfg;
    wr(OFF_PTR_LOW, 32'h40);
    wr(OFF_PTR_HIGH, {24'h0, expBase[15:8]});
    wr(OFF_PTR_UPPER, {26'h0, expBase[21:16]});
    for (int i = 0; i < 64; i++)
    begin
      expHold[i] = 8'($urandom);
      wr(OFF_LATCH, {24'h0, expHold[i]});
      wr(OFF_TABLE_WRITE_OP, $urandom);
    end
    check(nValid, 0);
    rdr(OFF_PTR_LOW);
    check(rd, 32'h80);
    rdr(OFF_PTR_UPPER);
    check(rd, {26'h0, expBase[21:16]});
    wr(OFF_PTR_LOW, 32'h40);
  endtask : fill

  ////////////////////////////////////////////////////////////////////////////
  // watch the byte stream and the stall time
  always @(posedge clk_sys)
  begin
    if (cpuStall === 1'b1)
      stallCnt++;
    if (flashWr.valid === 1'b1)
    begin
      check({10'h0, flashWr.addr}, {10'h0, exp_addr(expBase, nValid)});
      check({24'h0, flashWr.data}, {24'h0, expHold[nValid % 64]});
      check({31'h0, flashWr.cfgSpace}, {31'h0, expCfg});
      check({31'h0, flashWr.progMem}, 32'h1);
      nValid++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    int n;
    clk_sys = 1'b0; reset_n = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = '0; pwdata = '0; mclrRst = 1'b0; wdogRst = 1'b0;
    nMismatch = 0; checked = 0; nValid = 0; stallCnt = 0;
    expBase = '0; expCfg = 1'b0;
    void'($urandom(32'hC50534D1));
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    // every mapped register reads zero after reset
    for (int a = 0; a <= 32; a += 4)
    begin
      rdr(8'(a));
      check(rd, 32'h0);
      check({31'h0, err}, 32'h0);
    end
    // unmapped place refuses writes and reads zero
    wr(8'h24, $urandom);
    check({31'h0, err}, 32'h1);
    rdr(8'h24);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    // stray write inside the keys, then start without write enable
    for (int i = 0; i < 2; i++)
    begin
      start((i == 0) ? 8'h84 : 8'h80, i == 0);
      repeat (4) @(posedge clk_sys);
      check({31'h0, cpuStall}, 32'h0);
      rdr(OFF_CTRL);
      check({31'h0, rd[1]}, 32'h0);
      check(nValid + stallCnt, 0);
    end
    // blocks: plain, config space, watchdog abort, master clear abort
    for (int k = 0; k < 4; k++)
    begin
      wr(OFF_IRQ_MASK, (k == 0) ? 32'h0 : 32'h3);
      // counts start clean so the fill can show that nothing streams
      nValid   = 0;
      stallCnt = 0;
      fill(k == 1);
      start(8'h84, 1'b0);
      #1 check({31'h0, cpuStall}, 32'h1);
      rdr(OFF_CTRL);
      check(rd, 32'h86);
      if (k >= 2)
      begin
        repeat (20) @(posedge clk_sys);
        if (k == 2)
          wdogRst <= 1'b1;
        else
          mclrRst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check({31'h0, cpuStall}, 32'h0);
        wdogRst <= 1'b0;
        mclrRst <= 1'b0;
      end
      n = 0;
      while (cpuStall !== 1'b0 && n < 400)
      begin
        @(posedge clk_sys);
        n++;
      end
      if (n >= 400)
      begin
        nMismatch++;
        tally_and_finish();
      end
      if (k < 2)
      begin
        check(nValid, 64);
        check(stallCnt, 250);
      end
      else
        check({31'h0, nValid < 64}, 32'h1);
      rdr(OFF_CTRL);
      check(rd, (k < 2) ? 32'h84 : 32'h88);
      rdr(OFF_IRQ_STAT);
      check(rd, (k < 2) ? 32'h1 : 32'h2);
      #1 check({31'h0, irq}, (k == 0) ? 32'h0 : 32'h1);
      wr(OFF_IRQ_MASK, 32'h3);
      #1 check({31'h0, irq}, 32'h1);
      wr(OFF_IRQ_STAT, 32'h3);
      #1 check({31'h0, irq}, 32'h0);
      wr(OFF_CTRL, 32'h80);
      rdr(OFF_CTRL);
      check(rd, 32'h80);
    end
    tally_and_finish();
  end

endmodule : tb_top

/* logic/pfwc_sync2.sv */
// two-flop synchroniser for one asynchronous level.
// assumes the level may change at any time relative to clk_sys.
`timescale 1ns/100ps
module pfwc_sync2
(
  input  wire logic clk_sys,  // system clock
  input  wire logic reset_n,  // async reset, active low
  input  wire logic asyncIn,  // level from outside the domain
  output logic      syncOut   // level safe to use
);

  logic stage1_r;  // first flop, read only by the second

  //////////////////////////////////////////////////////////////////////////
  // two flops in a chain
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1_r <= 1'b0;
      syncOut  <= 1'b0;
    end
    else
    begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end

endmodule : pfwc_sync2

/* logic/pfwc_top.sv */
// program flash write control: APB registers, table write path into the
// holding register, unlock sequence, block programming with CPU stall.
// assumes reset event inputs come from pins and are asynchronous.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module pfwc_top
(
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [pfwc_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     masterClearReset,
  input  wire logic                     watchdogTimerReset,
  output logic                          cpuStall,
  output logic                          irq,
  output pfwc_pkg::pfwc_flash_wr_t      flashWr
);
  import pfwc_pkg::*;

  default clocking cbSys @(posedge clk_sys);  // clock of every check
  endclocking
  default disable iff (!reset_n);             // checks rest in reset

  //////////////////////////////////////////////////////////////////////////
  // state
  logic [PTR_W-1:0]   ptr_r, ptr_nxt;            // table_pointer
  logic [7:0]         latch_r, latch_nxt;        // table_latch_byte
  logic               progSel_r, progSel_nxt;    // program_memory_select
  logic               cfgSel_r, cfgSel_nxt;      // config_space_select
  logic               write_enable_bit_r, write_enable_bit_nxt;          // write_enable_bit
  logic               wrStart_r, wrStart_nxt;    // write start bit
  logic               write_error_flag_r, write_error_flag_nxt;        // write_error_flag
  logic [IRQ_W-1:0]   irqStat_r, irqStat_nxt;    // sticky events
  logic [IRQ_W-1:0]   irqMask_r, irqMask_nxt;    // event enables
  pfwc_unlock_t       ulState_r, ulState_nxt;    // unlock sequence
  pfwc_prog_t         pgState_r, pgState_nxt;    // programming state
  logic [HOLD_IW-1:0] idx_r, idx_nxt;            // byte being streamed
  logic [CNT_W-1:0]   cnt_r, cnt_nxt;            // programming time
  logic               tgtCfg_r, tgtCfg_nxt;      // latched target space
  logic               tgtProg_r, tgtProg_nxt;    // latched array select
  logic [PTR_W-1:HOLD_IW] base_r, base_nxt;      // block base address
  pfwc_flash_wr_t     flashWr_r, flashWr_nxt;    // array write port
  logic [31:0]        prdata_r, prdata_nxt;      // read data
  logic [7:0]         holdMem [HOLD_BYTES];      // holding register

  // combinational helpers and synchroniser outputs
  logic               apbWr;      // write access phase
  logic               apbRdSetup; // read setup phase
  logic               addrHit;    // address is mapped
  logic               holdWe;     // holding register write
  logic               startEvt;   // unlocked start accepted
  logic               doneEvt;    // block programming complete
  logic               rstEvt;     // reset event level, synchronised
  logic               mclrSync;   // synchronised master clear
  logic               wdtSync;    // synchronised watchdog reset
  logic               busy;       // write in progress
  logic [7:0]         ctrlRd;     // control register read view

  //////////////////////////////////////////////////////////////////////////
  // reset event inputs cross into clk_sys
  pfwc_sync2 u_syncMclr
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .asyncIn (masterClearReset),
    .syncOut (mclrSync)
  );
  pfwc_sync2 u_syncWdt
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .asyncIn (watchdogTimerReset),
    .syncOut (wdtSync)
  );

  //////////////////////////////////////////////////////////////////////////
  // bus decode and handshake, zero wait states
  assign rstEvt     = mclrSync | wdtSync;
  assign busy       = (pgState_r != PG_IDLE);
  assign apbWr      = psel & penable & pwrite & addrHit;
  assign apbRdSetup = psel & ~penable & ~pwrite;
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & ~addrHit;
  assign addrHit    = (paddr <= OFF_IRQ_MASK) && (paddr[1:0] == 2'b00);
  assign ctrlRd     = {progSel_r, cfgSel_r, 2'b00, write_error_flag_r, write_enable_bit_r,
                       wrStart_r, 1'b0};
  assign cpuStall   = busy;
  assign irq        = |(irqStat_r & irqMask_r);
  assign prdata     = prdata_r;
  assign flashWr    = flashWr_r;

  //////////////////////////////////////////////////////////////////////////
  // next state: software writes first, hardware events after (hardware wins)
  always_comb
  begin
    ptr_nxt     = ptr_r;
    latch_nxt   = latch_r;
    progSel_nxt = progSel_r;
    cfgSel_nxt  = cfgSel_r;
    write_enable_bit_nxt    = write_enable_bit_r;
    wrStart_nxt = wrStart_r;
    write_error_flag_nxt   = write_error_flag_r;
    irqStat_nxt = irqStat_r;
    irqMask_nxt = irqMask_r;
    ulState_nxt = ulState_r;
    pgState_nxt = pgState_r;
    idx_nxt     = idx_r;
    cnt_nxt     = cnt_r;
    tgtCfg_nxt  = tgtCfg_r;
    tgtProg_nxt = tgtProg_r;
    base_nxt    = base_r;
    flashWr_nxt = '0;
    prdata_nxt  = prdata_r;
    holdWe      = 1'b0;
    startEvt    = 1'b0;
    doneEvt     = 1'b0;
    // any write to a mapped register other than a key breaks the unlock sequence
    if (apbWr)
    begin
      ulState_nxt = UL_IDLE;
      case (paddr)
        OFF_PTR_LOW:   ptr_nxt[7:0]   = pwdata[7:0];
        OFF_PTR_HIGH:  ptr_nxt[15:8]  = pwdata[7:0];
        OFF_PTR_UPPER: ptr_nxt[21:16] = pwdata[5:0];
        OFF_LATCH:     latch_nxt      = pwdata[7:0];
        // first key from any state, second only right after the first
        OFF_UNLOCK:
          if (pwdata[7:0] == UNLOCK_KEY_A)
            ulState_nxt = UL_GOT_A;
          else if (pwdata[7:0] == UNLOCK_KEY_B && ulState_r == UL_GOT_A)
            ulState_nxt = UL_ARMED;
        OFF_CTRL:
        begin
          progSel_nxt = pwdata[CTRL_PROG_SEL];
          cfgSel_nxt  = pwdata[CTRL_CFG_SEL];
          write_enable_bit_nxt    = pwdata[CTRL_WR_EN];
          // error flag may only be cleared by software
          if (!pwdata[CTRL_WR_ERR])
            write_error_flag_nxt = 1'b0;
          // start bit only takes with write enable and an armed sequence
          if (pwdata[CTRL_WR_START] && write_enable_bit_r && ulState_r == UL_ARMED &&
              !busy)
            startEvt = 1'b1;
        end
        // copy latch into holding register, then post-increment
        OFF_TABLE_WRITE_OP:
          if (!busy)
          begin
            holdWe  = 1'b1;
            ptr_nxt = ptr_r + 22'h000001;
          end
        OFF_IRQ_STAT:  irqStat_nxt = irqStat_r & ~pwdata[IRQ_W-1:0];
        OFF_IRQ_MASK:  irqMask_nxt = pwdata[IRQ_W-1:0];
        default:       ;
      endcase
    end
    // programming sequence
    case (pgState_r)
      PG_IDLE:
        if (startEvt)
        begin
          pgState_nxt = PG_LOAD;
          wrStart_nxt = 1'b1;
          idx_nxt     = '0;
          cnt_nxt     = '0;
          tgtCfg_nxt  = ptr_r[PTR_CFG_BIT];
          tgtProg_nxt = progSel_r & ~cfgSel_r;
          base_nxt    = ptr_r[PTR_W-1:HOLD_IW];
        end
      PG_LOAD:
      begin
        // one holding byte to the array per cycle
        flashWr_nxt.valid    = 1'b1;
        flashWr_nxt.cfgSpace = tgtCfg_r;
        flashWr_nxt.progMem  = tgtProg_r;
        flashWr_nxt.addr     = {base_r, idx_r};
        flashWr_nxt.data     = holdMem[idx_r];
        idx_nxt              = idx_r + 6'h01;
        cnt_nxt              = cnt_r + 10'h001;
        if (idx_r == HOLD_LAST)
          pgState_nxt = PG_WAIT;
      end
      PG_WAIT:
      begin
        cnt_nxt = cnt_r + 10'h001;
        if (cnt_r == PROG_LAST)
        begin
          doneEvt               = 1'b1;
          pgState_nxt           = PG_IDLE;
          wrStart_nxt           = 1'b0;
          // an abort in the same cycle reports the error, not completion
          irqStat_nxt[IRQ_DONE] = irqStat_nxt[IRQ_DONE] | ~rstEvt;
        end
      end
      default: pgState_nxt = PG_IDLE;
    endcase
    // external reset events abort a running write and flag it
    if (rstEvt)
    begin
      ulState_nxt = UL_IDLE;
      write_enable_bit_nxt    = 1'b0;
      if (busy)
      begin
        pgState_nxt          = PG_IDLE;
        wrStart_nxt          = 1'b0;
        write_error_flag_nxt            = 1'b1;
        irqStat_nxt[IRQ_ERR] = 1'b1;
      end
    end
    // read data captured in the setup phase
    if (apbRdSetup)
    begin
      case (paddr)
        OFF_PTR_LOW:   prdata_nxt = {24'h000000, ptr_r[7:0]};
        OFF_PTR_HIGH:  prdata_nxt = {24'h000000, ptr_r[15:8]};
        OFF_PTR_UPPER: prdata_nxt = {26'h0000000, ptr_r[21:16]};
        OFF_LATCH:     prdata_nxt = {24'h000000, latch_r};
        OFF_CTRL:      prdata_nxt = {24'h000000, ctrlRd};
        OFF_IRQ_STAT:  prdata_nxt = {30'h00000000, irqStat_r};
        OFF_IRQ_MASK:  prdata_nxt = {30'h00000000, irqMask_r};
        default:       prdata_nxt = 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register stage
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ptr_r     <= RST_PTR;
      latch_r   <= RST_BYTE;
      progSel_r <= 1'b0;
      cfgSel_r  <= 1'b0;
      write_enable_bit_r    <= 1'b0;
      wrStart_r <= 1'b0;
      write_error_flag_r   <= 1'b0;
      irqStat_r <= RST_IRQ;
      irqMask_r <= RST_IRQ;
      ulState_r <= UL_IDLE;
      pgState_r <= PG_IDLE;
      idx_r     <= '0;
      cnt_r     <= '0;
      tgtCfg_r  <= 1'b0;
      tgtProg_r <= 1'b0;
      base_r    <= '0;
      flashWr_r <= '0;
      prdata_r  <= 32'h00000000;
    end
    else
    begin
      ptr_r     <= ptr_nxt;
      latch_r   <= latch_nxt;
      progSel_r <= progSel_nxt;
      cfgSel_r  <= cfgSel_nxt;
      write_enable_bit_r    <= write_enable_bit_nxt;
      wrStart_r <= wrStart_nxt;
      write_error_flag_r   <= write_error_flag_nxt;
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
      ulState_r <= ulState_nxt;
      pgState_r <= pgState_nxt;
      idx_r     <= idx_nxt;
      cnt_r     <= cnt_nxt;
      tgtCfg_r  <= tgtCfg_nxt;
      tgtProg_r <= tgtProg_nxt;
      base_r    <= base_nxt;
      flashWr_r <= flashWr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // holding register array, erased value after reset
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      for (int i = 0; i < HOLD_BYTES; i++)
        holdMem[i] <= RST_HOLD;
    else if (holdWe)
      holdMem[ptr_r[HOLD_IW-1:0]] <= latch_r;
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_start_needs_unlock;
    $rose(busy) |-> $past(ulState_r) == UL_ARMED && $past(write_enable_bit_r);
  endproperty
  a_start_needs_unlock: assert property (p_start_needs_unlock)
    else $error("write began without unlock sequence");
  property p_stall_while_busy;
    startEvt && !rstEvt |=> cpuStall && wrStart_r ##1 cpuStall[*8];
  endproperty
  a_stall_while_busy: assert property (p_stall_while_busy)
    else $error("cpu not stalled during write");
  property p_table_write_op_increment;
    holdWe |=> ptr_r == $past(ptr_r) + 22'h000001 &&
               holdMem[$past(ptr_r[HOLD_IW-1:0])] == $past(latch_r);
  endproperty
  a_table_write_op_increment: assert property (p_table_write_op_increment)
    else $error("table write did not copy and increment");
  property p_no_array_write_idle;
    flashWr_r.valid |-> $past(pgState_r) == PG_LOAD;
  endproperty
  a_no_array_write_idle: assert property (p_no_array_write_idle)
    else $error("array written outside programming");
  property p_cfg_space;
    startEvt && !rstEvt |-> ##2 flashWr_r.valid &&
      flashWr_r.cfgSpace == $past(ptr_r[PTR_CFG_BIT], 2);
  endproperty
  a_cfg_space: assert property (p_cfg_space)
    else $error("target space differs from pointer bit");
  property p_abort_error;
    busy && rstEvt |=> write_error_flag_r && !busy && irqStat_r[IRQ_ERR];
  endproperty
  a_abort_error: assert property (p_abort_error)
    else $error("aborted write not flagged");
  property p_done;
    doneEvt && !rstEvt |=> !wrStart_r && irqStat_r[IRQ_DONE] && !busy;
  endproperty
  a_done: assert property (p_done)
    else $error("completion did not clear start or set flag");

  c_start: cover property (startEvt);
  c_done: cover property (doneEvt);
  c_abort: cover property (busy && rstEvt);

endmodule : pfwc_top

/* pkg/pfwc_pkg.sv */
// package of the program flash write control block: register map, fields,
// reset values, unlock keys, timing counts, state and carrier types.
// assumes a 250 MHz system clock and a 32-bit APB register bus.
//
// Contract
// - write 55h, AAh to unlock, then start
// - start after unlock programs block, stalls CPU
// - table write copies latch, then increments pointer
// - pointer bit 21 selects configuration space
// - reset during write sets write error flag
package pfwc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register byte offsets on the APB
  localparam int        APB_AW        = 8;      // address bits decoded
  localparam logic [7:0] OFF_PTR_LOW   = 8'h00;  // table_pointer_low
  localparam logic [7:0] OFF_PTR_HIGH  = 8'h04;  // table_pointer_high
  localparam logic [7:0] OFF_PTR_UPPER = 8'h08;  // table_pointer_upper
  localparam logic [7:0] OFF_LATCH     = 8'h0C;  // table_latch
  localparam logic [7:0] OFF_UNLOCK    = 8'h10;  // unlock_sequence_port
  localparam logic [7:0] OFF_CTRL      = 8'h14;  // memory_write_control
  localparam logic [7:0] OFF_TABLE_WRITE_OP     = 8'h18;  // table write op trigger
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h1C;  // sticky event flags
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h20;  // event enables

  //////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_PROG_SEL = 7;  // program_memory_select
  localparam int CTRL_CFG_SEL  = 6;  // config_space_select
  localparam int CTRL_WR_ERR   = 3;  // write_error_flag
  localparam int CTRL_WR_EN    = 2;  // write_enable_bit
  localparam int CTRL_WR_START = 1;  // write start bit
  localparam int IRQ_DONE      = 0;  // memory_write_irq_flag
  localparam int IRQ_ERR       = 1;  // write aborted by reset
  localparam int IRQ_W         = 2;  // number of event bits
  localparam int PTR_W         = 22; // table_pointer width
  localparam int PTR_CFG_BIT   = 21; // configuration space select bit
  localparam int HOLD_IW       = 6;  // holding register index width
  localparam int HOLD_BYTES    = 64; // bytes per programmed block

  //////////////////////////////////////////////////////////////////////////
  // keys and reset values
  localparam logic [7:0]         UNLOCK_KEY_A = 8'h55;
  localparam logic [7:0]         UNLOCK_KEY_B = 8'hAA;
  localparam logic [PTR_W-1:0]   RST_PTR      = 22'h000000;
  localparam logic [7:0]         RST_BYTE     = 8'h00;
  localparam logic [7:0]         RST_HOLD     = 8'hFF; // erased flash value
  localparam logic [IRQ_W-1:0]   RST_IRQ      = 2'h0;
  localparam logic [HOLD_IW-1:0] HOLD_LAST    = 6'h3F;

  //////////////////////////////////////////////////////////////////////////
  // timing: programming time of one block
  localparam int PROG_TIME_NS = 1000;
  localparam int CLK_MHZ      = 250;
  localparam int PROG_CYCLES  = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W        = 10;
  localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////
  // state and carrier types
  typedef enum logic [1:0]
  {
    UL_IDLE  = 2'b00,  // no key seen
    UL_GOT_A = 2'b01,  // first key seen
    UL_ARMED = 2'b10   // both keys seen, start may follow
  } pfwc_unlock_t;

  typedef enum logic [1:0]
  {
    PG_IDLE = 2'b00,  // no write running
    PG_LOAD = 2'b01,  // streaming holding bytes to the array
    PG_WAIT = 2'b10   // waiting out the programming time
  } pfwc_prog_t;

  typedef struct packed
  {
    logic             valid;    // one-cycle byte strobe
    logic             cfgSpace; // byte goes to configuration space
    logic             progMem;  // program array selected by software
    logic [PTR_W-1:0] addr;     // byte address
    logic [7:0]       data;     // byte value
  } pfwc_flash_wr_t;

endpackage : pfwc_pkg
